/* logic/rntx_transfer.sv */
/*
  executes the converter-result read and holding-pair read into accumulator and auxiliary register.
  assumes the core presents one instruction word per cycle with instrValid, and that
  the converter side keeps its result, comparator, holding and control registers stable
  in the cycle the instruction is taken.
*/
`timescale 1ns/100ps
`include "rntx_cfg.svh"
module rntx_transfer
  import rntx_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic instrValid,
  input wire logic [9:0] instrWord,
  input wire logic carryIn,
  input wire rntx_src_t src,
  output rntx_pair_t pair,
  output logic pairLoaded,
  output logic carryOut,
  output logic skipReq,
  output logic instrDone
);
  // ----------------------------------------
  // decode
  // ----------------------------------------
  rntx_op_t op;
  rntx_pair_t next_pair;
  logic next_pairLoaded;
  logic next_carryOut;
  logic next_instrDone;
  logic next_skipReq;
  logic compareMode;
  rntx_pair_t resultSel;

  rntx_decode u_decode (
    .instrWord(instrWord),
    .op(op)
  );

  assign compareMode = src.converterControlReg[`RNTX_CTRL_MODE_BIT];

  // ----------------------------------------
  // source select
  // ----------------------------------------
  always_comb begin
    if (compareMode) begin
      resultSel.aux = src.compareReg[7:4];
      resultSel.acc = src.compareReg[3:0];
    end else begin
      resultSel.aux = src.convResult[9:6];
      resultSel.acc = src.convResult[5:2];
    end
  end

  // ----------------------------------------
  // execute
  // ----------------------------------------
  always_comb begin
    next_pair = pair;
    next_pairLoaded = 1'b0;
    next_instrDone = instrValid;
    next_carryOut = carryIn;
    next_skipReq = 1'b0;
    if (instrValid) begin
      case (op)
        RNTX_OP_RESULT: begin
          next_pairLoaded = 1'b1;
          next_pair = resultSel;
        end
        RNTX_OP_HOLDING: begin
          next_pairLoaded = 1'b1;
          next_pair.aux = src.holdingReg[7:4];
          next_pair.acc = src.holdingReg[3:0];
        end
        default: next_pairLoaded = 1'b0;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pair <= {`RNTX_NIBBLE_RESET, `RNTX_NIBBLE_RESET};
      pairLoaded <= 1'b0;
      carryOut <= 1'b0;
      skipReq <= 1'b0;
      instrDone <= 1'b0;
    end else begin
      pair <= next_pair;
      pairLoaded <= next_pairLoaded;
      carryOut <= next_carryOut;
      skipReq <= next_skipReq;
      instrDone <= next_instrDone;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_result_decode;
    @(posedge sys_clk) disable iff (rst)
    (instrValid && instrWord == 10'h279) |=> pairLoaded;
  endproperty
  a_result_decode: assert property (p_result_decode) else $error("result read not executed");

  property p_one_cycle;
    @(posedge sys_clk) disable iff (rst)
    (instrValid && op != RNTX_OP_NONE) |=> (instrDone && pairLoaded && !skipReq && carryOut == $past(carryIn));
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("transfer not single cycle or altered carry/skip");

  property p_mode_conv;
    @(posedge sys_clk) disable iff (rst)
    (instrValid && op == RNTX_OP_RESULT && !src.converterControlReg[3]) |=> (pair.aux == $past(src.convResult[9:6]));
  endproperty
  a_mode_conv: assert property (p_mode_conv) else $error("mode bit source wrong");

  property p_conv_acc;
    @(posedge sys_clk) disable iff (rst)
    (instrValid && op == RNTX_OP_RESULT && !compareMode) |=> (pair.acc == $past(src.convResult[5:2]));
  endproperty
  a_conv_acc: assert property (p_conv_acc) else $error("conversion mode accumulator wrong");

  property p_cmp_pair;
    @(posedge sys_clk) disable iff (rst)
    (instrValid && op == RNTX_OP_RESULT && compareMode) |=> (pair == $past(src.compareReg));
  endproperty
  a_cmp_pair: assert property (p_cmp_pair) else $error("comparator mode pair wrong");

  property p_holding_decode;
    @(posedge sys_clk) disable iff (rst)
    (instrValid && instrWord == 10'h02A) |=> pairLoaded;
  endproperty
  a_holding_decode: assert property (p_holding_decode) else $error("holding read not executed");

  property p_holding_pair;
    @(posedge sys_clk) disable iff (rst)
    (instrValid && op == RNTX_OP_HOLDING) |=> (pair == $past(src.holdingReg));
  endproperty
  a_holding_pair: assert property (p_holding_pair) else $error("holding pair wrong");

  property p_hold_idle;
    @(posedge sys_clk) disable iff (rst)
    !pairLoaded |-> (pair == $past(pair));
  endproperty
  a_hold_idle: assert property (p_hold_idle) else $error("pair changed without transfer");

  property p_refused_hold;
    @(posedge sys_clk) disable iff (rst)
    (instrValid && op == RNTX_OP_NONE) |=> (!pairLoaded && pair == $past(pair));
  endproperty
  a_refused_hold: assert property (p_refused_hold) else $error("unknown word touched the pair");

  property p_idle_hold;
    @(posedge sys_clk) disable iff (rst)
    !instrValid |=> (!pairLoaded && !instrDone && pair == $past(pair));
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("activity without an instruction");

  property p_done_valid;
    @(posedge sys_clk) disable iff (rst)
    instrValid |=> instrDone;
  endproperty
  a_done_valid: assert property (p_done_valid) else $error("instruction not finished in one cycle");

  property p_no_skip;
    @(posedge sys_clk) disable iff (rst)
    !skipReq;
  endproperty
  a_no_skip: assert property (p_no_skip) else $error("skip requested by a transfer");

  property p_carry_kept;
    @(posedge sys_clk) disable iff (rst)
    1'b1 |=> (carryOut == $past(carryIn));
  endproperty
  a_carry_kept: assert property (p_carry_kept) else $error("carry flag altered");

  property p_mode_cmp_aux;
    @(posedge sys_clk) disable iff (rst)
    (instrValid && op == RNTX_OP_RESULT && src.converterControlReg[`RNTX_CTRL_MODE_BIT]) |=>
      (pair.aux == $past(src.compareReg[7:4]));
  endproperty
  a_mode_cmp_aux: assert property (p_mode_cmp_aux) else $error("mode bit set but comparator not chosen");

  property p_cmp_acc;
    @(posedge sys_clk) disable iff (rst)
    (instrValid && op == RNTX_OP_RESULT && compareMode) |=> (pair.acc == $past(src.compareReg[3:0]));
  endproperty
  a_cmp_acc: assert property (p_cmp_acc) else $error("comparator mode accumulator wrong");

  property p_result_word;
    @(posedge sys_clk) disable iff (rst)
    (instrValid && instrWord == `RNTX_OP_READ_RESULT && !compareMode) |=> (pair == $past(src.convResult[9:2]));
  endproperty
  a_result_word: assert property (p_result_word) else $error("result read word gave wrong pair");

  property p_holding_word;
    @(posedge sys_clk) disable iff (rst)
    (instrValid && instrWord == `RNTX_OP_READ_HOLDING) |=> (pair == $past(src.holdingReg));
  endproperty
  a_holding_word: assert property (p_holding_word) else $error("holding read word gave wrong pair");

  property p_loaded_cause;
    @(posedge sys_clk) disable iff (rst)
    pairLoaded |-> ($past(instrValid) && $past(op) != RNTX_OP_NONE);
  endproperty
  a_loaded_cause: assert property (p_loaded_cause) else $error("pair loaded without a transfer word");

  property p_holding_mode_free;
    @(posedge sys_clk) disable iff (rst)
    (instrValid && op == RNTX_OP_HOLDING && compareMode) |=> (pair.aux == $past(src.holdingReg[7:4]));
  endproperty
  a_holding_mode_free: assert property (p_holding_mode_free) else $error("holding read followed the mode bit");

  // ----------------------------------------
  // covers
  // ----------------------------------------
  c_conv: cover property (@(posedge sys_clk) disable iff (rst) instrValid && op == RNTX_OP_RESULT && !compareMode);
  c_cmp: cover property (@(posedge sys_clk) disable iff (rst) instrValid && op == RNTX_OP_RESULT && compareMode);
  c_hold: cover property (@(posedge sys_clk) disable iff (rst) instrValid && op == RNTX_OP_HOLDING);
  c_b2b: cover property (@(posedge sys_clk) disable iff (rst) pairLoaded ##1 pairLoaded);
  c_refused: cover property (@(posedge sys_clk) disable iff (rst) instrValid && op == RNTX_OP_NONE);
endmodule : rntx_transfer

/* logic/rntx_cfg.svh */
/*
  constants for the result nibble transfer decoder: opcodes, field positions, reset values.
  assumes inclusion by bare name from the transfer and decode modules.
*/
`ifndef RNTX_CFG_SVH
`define RNTX_CFG_SVH
`define RNTX_OP_READ_RESULT 10'h279
`define RNTX_OP_READ_HOLDING 10'h02A
`define RNTX_CTRL_MODE_BIT 3
`define RNTX_NIBBLE_RESET 4'h0
`define RNTX_EXEC_CYCLES 1
`endif

/* logic/rntx_pkg.sv */
/*
  types shared by the result nibble transfer decoder.
  assumes the cfg header is on the include path.
*/
package rntx_pkg;
  typedef enum logic [1:0] {
    RNTX_OP_NONE = 2'b00,
    RNTX_OP_RESULT = 2'b01,
    RNTX_OP_HOLDING = 2'b11
  } rntx_op_t;

  typedef struct packed {
    logic [3:0] aux;
    logic [3:0] acc;
  } rntx_pair_t;

  typedef struct packed {
    logic [9:0] convResult;
    logic [7:0] compareReg;
    logic [7:0] holdingReg;
    logic [3:0] converterControlReg;
  } rntx_src_t;
endpackage : rntx_pkg

/* logic/rntx_decode.sv */
/*
  opcode classifier for the two transfer instructions.
  assumes a registered instruction word from the core's fetch logic.
*/
`timescale 1ns/100ps
`include "rntx_cfg.svh"
module rntx_decode
  import rntx_pkg::*;
(
  input wire logic [9:0] instrWord,
  output rntx_op_t op
);
  always_comb begin
    case (instrWord)
      `RNTX_OP_READ_RESULT: op = RNTX_OP_RESULT;
      `RNTX_OP_READ_HOLDING: op = RNTX_OP_HOLDING;
      default: op = RNTX_OP_NONE;
    endcase
  end
endmodule : rntx_decode

/* bench/rntx_src_model.sv */
/*
  converter side model: result, comparator, holding and control registers.
  assumes the bench hands a new register image each cycle; it shows up after the next edge.
*/
`timescale 1ns/100ps
module rntx_src_model
  import rntx_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [29:0] newImage,
  output rntx_src_t src
);
  // ----------------------------------------
  // register image, held stable for a cycle
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      src <= '0;
    end else begin
      src <= newImage;
    end
  end
endmodule : rntx_src_model

/* bench/result_nibble_transfer_instrs_tb.sv */
/*
  self-checking bench for the transfer decoder, random words with corner opcodes.
  assumes the converter model and the design package are compiled first.
*/
`timescale 1ns/100ps
module result_nibble_transfer_instrs_tb;
  import rntx_pkg::*;
  logic sys_clk = 0, rst = 1, instrValid = 0, carryIn = 0;
  logic [9:0] instrWord = '0;
  logic [29:0] newImage = '0;
  rntx_src_t src;
  rntx_pair_t pair;
  logic pairLoaded, carryOut, skipReq, instrDone;
  logic [7:0] expPair;
  logic expLoaded, expDone, expCarry;
  int fails = 0, comparisons = 0, seed = 3, r;
  always #5 sys_clk = ~sys_clk;
  rntx_src_model u_rntx_src_model (.sys_clk(sys_clk), .rst(rst), .newImage(newImage), .src(src));
  rntx_transfer u_rntx_transfer (.sys_clk(sys_clk), .rst(rst), .instrValid(instrValid),
    .instrWord(instrWord), .carryIn(carryIn), .src(src), .pair(pair), .pairLoaded(pairLoaded),
    .carryOut(carryOut), .skipReq(skipReq), .instrDone(instrDone));
  // ----------------------------------------
  // checking helpers
  // ----------------------------------------
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [7:0] exp_pair(input rntx_src_t s, input logic [9:0] w, input logic [7:0] old);
    if (w == 10'h279) return s.converterControlReg[3] ? s.compareReg : s.convResult[9:2];
    if (w == 10'h02A) return s.holdingReg;
    return old;
  endfunction : exp_pair
  task report_and_stop;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  initial begin
    #50000;
    fails++;
    report_and_stop;
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    #1 rst = 0;
    chk({pair, pairLoaded, instrDone, carryOut, skipReq}, 12'h000);
    expPair = '0;
    for (int i = 0; i < 400; i++) begin
      @(posedge sys_clk);
      #1;
      if (i > 0) begin
        chk(pair, expPair);
        chk(pairLoaded, expLoaded);
        chk(instrDone, expDone);
        chk({carryOut, skipReq}, {expCarry, 1'b0});
      end
      r = $random(seed) & 3;
      instrWord = (r == 0) ? 10'h279 : (r == 1) ? 10'h02A : 10'($random(seed));
      if (($random(seed) & 7) == 7) instrWord = instrWord ^ (10'h001 << ($random(seed) & 7));
      instrValid = ($random(seed) & 3) != 0;
      carryIn = $random(seed);
      newImage = 30'($random(seed));
      expLoaded = instrValid && (instrWord == 10'h279 || instrWord == 10'h02A);
      expPair = instrValid ? exp_pair(src, instrWord, expPair) : expPair;
      expDone = instrValid;
      expCarry = carryIn;
    end
    // last word's result, then a second reset at the end of the run
    @(posedge sys_clk);
    #1;
    chk(pair, expPair);
    rst = 1;
    instrValid = 0;
    repeat (2) @(posedge sys_clk);
    #1 rst = 0;
    chk({pair, pairLoaded, instrDone, carryOut, skipReq}, 12'h000);
    report_and_stop;
  end
endmodule : result_nibble_transfer_instrs_tb
